// File: hdl/nfcc_defs.svh
`ifndef NFCC_DEFS_SVH
`define NFCC_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define NFCC_CTRL_OFS 8'h00
`define NFCC_CFGPORT_OFS 8'h04
`define NFCC_STATUS_OFS 8'h08
`define NFCC_GEOM_OFS 8'h0C
`define NFCC_PROT_OFS 8'h10
`define NFCC_DERIV_OFS 8'h14
`define NFCC_ACTION_OFS 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NFCC_CTRL_EN_BIT 0
`define NFCC_STAT_RUN_BIT 0
`define NFCC_STAT_CFGD_BIT 1
`define NFCC_STAT_CFGERR_BIT 2
`define NFCC_STAT_ILL_BIT 3
`define NFCC_STAT_PTR_LSB 4
`define NFCC_SUB1_CARD_BIT 0
`define NFCC_SUB1_NDEV_LSB 5
`define NFCC_SUB2_BSIZE_LSB 0
`define NFCC_DERIV_PPB_LSB 0
`define NFCC_DERIV_PGB_LSB 16

// ----------------------------------------------------------------
// descriptor byte positions
// ----------------------------------------------------------------
`define NFCC_POS_FLASH_PG 3'h0
`define NFCC_POS_CARD_PG 3'h1
`define NFCC_POS_SUB1 3'h2
`define NFCC_POS_SUB2 3'h3
`define NFCC_POS_FPB_HI 3'h4
`define NFCC_POS_FPB_LO 3'h5
`define NFCC_POS_LPB_HI 3'h6
`define NFCC_POS_LPB_LO 3'h7

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define NFCC_DESC_RST 64'h0000_0000_001E_0000
`define NFCC_MAX_DEV 3'h4
`define NFCC_MAX_DEV_CARD 3'h3
`define NFCC_MAX_PG_UNITS 5'h10
`define NFCC_MIN_PPB 9'h020
`define NFCC_UNIT_SHIFT 9

// ----------------------------------------------------------------
// basic operation codes and bus answers
// ----------------------------------------------------------------
`define NFCC_OP_NONE 3'h0
`define NFCC_OP_READ_ID 3'h1
`define NFCC_OP_WRITE_BYTE 3'h2
`define NFCC_OP_ERASE_BLOCK 3'h3
`define NFCC_RESP_OKAY 2'h0
`define NFCC_RESP_SLVERR 2'h2

`endif

// File: hdl/nfcc_pkg.sv
package nfcc_pkg;

	// controller life cycle
	typedef enum logic [1:0]
	{
		ST_OFF,
		ST_UNCONF,
		ST_LOAD,
		ST_IDLE
	} nfcc_state_t;

	typedef logic [7:0] nfcc_byte_t;
	typedef logic [2:0] nfcc_pos_t;

endpackage

// File: hdl/nfcc_desc_if.sv
`timescale 1ns/10ps

// descriptor store access: one byte write port, whole descriptor out
interface nfcc_desc_if;
	logic wr_en;
	nfcc_pkg::nfcc_pos_t wr_pos;
	nfcc_pkg::nfcc_byte_t wr_data;
	logic [63:0] desc;

	modport ctrl
	(
		output wr_en,
		output wr_pos,
		output wr_data,
		input desc
	);

	modport store
	(
		input wr_en,
		input wr_pos,
		input wr_data,
		output desc
	);
endinterface

// File: hdl/nfcc_desc_store.sv
`timescale 1ns/10ps
`include "nfcc_defs.svh"

module nfcc_desc_store
	import nfcc_pkg::*;
#(
	parameter int NBYTES = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	nfcc_desc_if.store dif
);

	localparam logic [63:0] RST = `NFCC_DESC_RST;

	initial
	begin
		if (NBYTES != 8)
			$error("nfcc_desc_store: descriptor must hold eight bytes");
	end

	// ----------------------------------------------------------------
	// one flop byte per descriptor position
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NBYTES; gi++)
		begin : g_byte
			logic [7:0] byte_q;

			// [RULE9] reset defaults per byte
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					byte_q <= RST[gi*8 +: 8];
				else if (dif.wr_en && dif.wr_pos == nfcc_pos_t'(gi))
					byte_q <= dif.wr_data;
			end

			assign dif.desc[gi*8 +: 8] = byte_q;
		end
	endgenerate

endmodule

// File: hdl/nfcc_top.sv
// Function
// [RULE1] configuration accepted only while controller enabled
// [RULE2] software loads descriptor before any operation
// [RULE3] eight descriptor bytes, one per write, from 0
// [RULE4] further full descriptor replaces the previous one
// [RULE5] position 0 flash page, 1 card page
// [RULE6] positions 2 and 3 sub-configuration bytes
// [RULE7] positions 4,5 first protected block high/low
// [RULE8] positions 6,7 last protected block high/low
// [RULE9] protected block bytes reset to zero
// [RULE10] only basic device operations are issued
// [RULE11] four devices, three with card enabled
// [RULE12] pages 512 to 8192 bytes supported
// [RULE13] block size field selects 32..256 pages
// [RULE14] configured controller idles with running flag clear
// [RULE15] byte pointer advances, wraps after position 7
`timescale 1ns/10ps
`include "nfcc_defs.svh"

module nfcc_top
	import nfcc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic flash_ctrl_enable,
	output logic running_flag,
	output logic op_strobe,
	output logic [2:0] op_code
);

	initial
	begin
		if (ADDR_W < 8 || ADDR_W > 32)
			$error("nfcc_top: ADDR_W must lie in 8..32");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic enable_q, configured_q, running_q, illegal_q;
	logic op_strobe_q;
	logic [2:0] op_code_q;
	nfcc_pos_t ptr_q;
	nfcc_state_t state_q, state_d;

	nfcc_desc_if dif();

	nfcc_desc_store #(.NBYTES(8)) u_store
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.dif(dif)
	);

	// ----------------------------------------------------------------
	// descriptor field decode
	// ----------------------------------------------------------------
	logic [7:0] flash_page_geometry, card_page_geometry;
	logic [7:0] sub_config_first, sub_config_second;
	logic [7:0] first_prot_block_high, first_prot_block_low;
	logic [7:0] last_prot_block_high, last_prot_block_low;
	logic [4:0] flash_units, card_units;
	logic [1:0] pages_per_block_sel, dev_count_m1;
	logic card_enable;
	logic [8:0] pages_per_block;
	logic [13:0] flash_page_bytes;
	logic cfg_err;

	// [RULE5] page geometry bytes
	assign flash_page_geometry = dif.desc[`NFCC_POS_FLASH_PG*8 +: 8];
	assign card_page_geometry = dif.desc[`NFCC_POS_CARD_PG*8 +: 8];
	// [RULE6] sub-configuration bytes
	assign sub_config_first = dif.desc[`NFCC_POS_SUB1*8 +: 8];
	assign sub_config_second = dif.desc[`NFCC_POS_SUB2*8 +: 8];
	// [RULE7] first protected block
	assign first_prot_block_high = dif.desc[`NFCC_POS_FPB_HI*8 +: 8];
	assign first_prot_block_low = dif.desc[`NFCC_POS_FPB_LO*8 +: 8];
	// [RULE8] last protected block
	assign last_prot_block_high = dif.desc[`NFCC_POS_LPB_HI*8 +: 8];
	assign last_prot_block_low = dif.desc[`NFCC_POS_LPB_LO*8 +: 8];

	// page size in 512-byte units, top unit bit sits below the others
	assign flash_units = {flash_page_geometry[3], flash_page_geometry[7:4]};
	assign card_units = {card_page_geometry[3], card_page_geometry[7:4]};
	assign card_enable = sub_config_first[`NFCC_SUB1_CARD_BIT];
	assign dev_count_m1 = sub_config_first[`NFCC_SUB1_NDEV_LSB +: 2];
	assign pages_per_block_sel = sub_config_second[`NFCC_SUB2_BSIZE_LSB +: 2];

	// [RULE13] pages per block from size select
	assign pages_per_block = `NFCC_MIN_PPB << pages_per_block_sel;
	// [RULE12] page bytes, unit of 512
	assign flash_page_bytes = 14'(flash_units) << `NFCC_UNIT_SHIFT;

	// configuration consistency check
	always_comb
	begin
		cfg_err = 1'b0;
		// [RULE11] device count limit
		if ({1'b0, dev_count_m1} + 3'h1 > (card_enable ? `NFCC_MAX_DEV_CARD : `NFCC_MAX_DEV))
			cfg_err = 1'b1;
		// [RULE12] page size range check
		if (flash_units == 5'h00 || flash_units > `NFCC_MAX_PG_UNITS)
			cfg_err = 1'b1;
		if (card_enable && (card_units == 5'h00 || card_units > `NFCC_MAX_PG_UNITS))
			cfg_err = 1'b1;
	end

	// ----------------------------------------------------------------
	// axi write channels
	// ----------------------------------------------------------------
	logic wr_go;
	logic [2:0] wr_idx;
	logic wr_mapped;

	assign wr_go = aw_have_q && w_have_q && !bvalid_q;
	assign wr_idx = awaddr_q[4:2];
	assign wr_mapped = (awaddr_q[ADDR_W-1:5] == '0) && (awaddr_q[4:0] <= 5'(`NFCC_ACTION_OFS));

	// address and data captured in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_q)
			begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (bvalid_q && s_axi_bready)
				awready_q <= 1'b1;
			if (s_axi_wvalid && wready_q)
			begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (bvalid_q && s_axi_bready)
				wready_q <= 1'b1;
			if (wr_go)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `NFCC_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? `NFCC_RESP_OKAY : `NFCC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// register write decode
	// ----------------------------------------------------------------
	logic sel_ctrl, cfg_wr, act_wr, stat_wr, act_legal;
	logic [2:0] act_code;

	assign sel_ctrl = wr_go && wr_mapped && wr_idx == 3'(`NFCC_CTRL_OFS >> 2) && wstrb_q[0];
	// [RULE1] configuration writes need enable
	assign cfg_wr = wr_go && wr_mapped && wr_idx == 3'(`NFCC_CFGPORT_OFS >> 2) && wstrb_q[0]
		&& enable_q;
	assign act_wr = wr_go && wr_mapped && wr_idx == 3'(`NFCC_ACTION_OFS >> 2) && wstrb_q[0];
	assign stat_wr = wr_go && wr_mapped && wr_idx == 3'(`NFCC_STATUS_OFS >> 2) && wstrb_q[0];
	assign act_code = wdata_q[2:0];

	// [RULE10] only basic operations are legal
	assign act_legal = enable_q && state_q == ST_IDLE && !cfg_err
		&& (act_code == `NFCC_OP_READ_ID || act_code == `NFCC_OP_WRITE_BYTE
		|| act_code == `NFCC_OP_ERASE_BLOCK);

	// [RULE3] byte goes to pointed position
	assign dif.wr_en = cfg_wr;
	assign dif.wr_pos = ptr_q;
	assign dif.wr_data = wdata_q[7:0];

	// controller enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			enable_q <= 1'b0;
		else if (sel_ctrl)
			enable_q <= wdata_q[`NFCC_CTRL_EN_BIT];
	end

	// descriptor byte pointer
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !enable_q)
			ptr_q <= 3'h0;
		// [RULE15] advance and wrap
		else if (cfg_wr)
			ptr_q <= ptr_q + 3'h1;
	end

	// ----------------------------------------------------------------
	// controller life cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (enable_q)
					state_d = configured_q ? ST_IDLE : ST_UNCONF;
			ST_UNCONF:
				if (!enable_q)
					state_d = ST_OFF;
				else if (cfg_wr)
					state_d = ST_LOAD;
			ST_LOAD:
				if (!enable_q)
					state_d = ST_OFF;
				else if (cfg_wr && ptr_q == `NFCC_POS_LPB_LO)
					state_d = ST_IDLE;
			ST_IDLE:
				if (!enable_q)
					state_d = ST_OFF;
				// [RULE4] new descriptor reloads
				else if (cfg_wr)
					state_d = ST_LOAD;
			default:
				state_d = ST_OFF;
		endcase
	end

	// state, running flag and configured mark
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_OFF;
			running_q <= 1'b0;
			configured_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			// [RULE14] idle clears running flag
			running_q <= (state_d == ST_LOAD);
			if (state_q == ST_LOAD && state_d == ST_IDLE)
				configured_q <= 1'b1;
			else if (state_d == ST_LOAD)
				configured_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// operation launch and illegal request flag
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_strobe_q <= 1'b0;
			op_code_q <= `NFCC_OP_NONE;
		end
		// [RULE2] launch only once configured
		else if (act_wr && act_legal)
		begin
			op_strobe_q <= 1'b1;
			op_code_q <= act_code;
		end
		else
			op_strobe_q <= 1'b0;
	end

	// sticky, write one to clear, a new event wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			illegal_q <= 1'b0;
		else if (act_wr && !act_legal && act_code != `NFCC_OP_NONE)
			illegal_q <= 1'b1;
		else if (stat_wr && wdata_q[`NFCC_STAT_ILL_BIT])
			illegal_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// axi read channels
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_mapped;

	assign rd_mapped = (s_axi_araddr[ADDR_W-1:5] == '0)
		&& (s_axi_araddr[4:0] <= 5'(`NFCC_ACTION_OFS));

	// read data select
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr[4:2])
			3'(`NFCC_CTRL_OFS >> 2):
				rd_word[`NFCC_CTRL_EN_BIT] = enable_q;
			3'(`NFCC_CFGPORT_OFS >> 2):
				rd_word[2:0] = ptr_q;
			3'(`NFCC_STATUS_OFS >> 2):
			begin
				rd_word[`NFCC_STAT_RUN_BIT] = running_q;
				rd_word[`NFCC_STAT_CFGD_BIT] = configured_q;
				rd_word[`NFCC_STAT_CFGERR_BIT] = cfg_err;
				rd_word[`NFCC_STAT_ILL_BIT] = illegal_q;
				rd_word[`NFCC_STAT_PTR_LSB +: 3] = ptr_q;
			end
			3'(`NFCC_GEOM_OFS >> 2):
				rd_word = {sub_config_second, sub_config_first, card_page_geometry,
					flash_page_geometry};
			3'(`NFCC_PROT_OFS >> 2):
				rd_word = {last_prot_block_low, last_prot_block_high, first_prot_block_low,
					first_prot_block_high};
			3'(`NFCC_DERIV_OFS >> 2):
			begin
				rd_word[`NFCC_DERIV_PPB_LSB +: 9] = pages_per_block;
				rd_word[`NFCC_DERIV_PGB_LSB +: 14] = flash_page_bytes;
			end
			3'(`NFCC_ACTION_OFS >> 2):
				rd_word[2:0] = op_code_q;
			default:
				rd_word = 32'h0000_0000;
		endcase
		if (!rd_mapped)
			rd_word = 32'h0000_0000;
	end

	// read answer one cycle after address taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `NFCC_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_q)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_mapped ? `NFCC_RESP_OKAY : `NFCC_RESP_SLVERR;
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign flash_ctrl_enable = enable_q;
	assign running_flag = running_q;
	assign op_strobe = op_strobe_q;
	assign op_code = op_code_q;

endmodule

// File: sim/nfcc_checker.sv
`timescale 1ns/10ps
`include "nfcc_defs.svh"

module nfcc_checker
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic flash_ctrl_enable,
	input wire logic running_flag,
	input wire logic op_strobe,
	input wire logic [2:0] op_code
);
	logic [ADDR_W-1:0] addr_q;
	logic [1:0] wbit_q;

	// latch write address and enable lane as each is taken
	always_ff @(posedge aclk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			addr_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			wbit_q <= {s_axi_wstrb[0], s_axi_wdata[0]};
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------------------------------
	// bus and launch checks
	// ----------------------------------------------------------------
	sequence b_hs;
		s_axi_bvalid && s_axi_bready;
	endsequence
	sequence run_start;
		$rose(running_flag);
	endsequence

	a_op_basic: assert property (op_strobe |-> op_code inside {3'h1, 3'h2, 3'h3})
		else $error("launch with non basic code");
	a_op_single: assert property (op_strobe |=> !op_strobe)
		else $error("launch strobe longer than one cycle");
	a_op_cause: assert property (op_strobe |-> $rose(s_axi_bvalid)
		&& addr_q == `NFCC_ACTION_OFS && flash_ctrl_enable && !running_flag)
		else $error("launch without legal action write");
	a_enable_copy: assert property ($rose(s_axi_bvalid) && addr_q == `NFCC_CTRL_OFS
		&& wbit_q[1] |-> ##[0:1] flash_ctrl_enable == wbit_q[0])
		else $error("enable does not follow control write");
	a_run_begin: assert property (run_start
		|-> s_axi_bvalid && addr_q == `NFCC_CFGPORT_OFS)
		else $error("running flag rose without config write");
	a_run_end: assert property ($fell(running_flag)
		|-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("running flag fell without a write");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_ready_back: assert property (b_hs |=> s_axi_awready && s_axi_wready)
		else $error("write channels not reopened");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
endmodule

bind nfcc_top nfcc_checker #(.ADDR_W(ADDR_W)) i_nfcc_checker
(
	.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.flash_ctrl_enable(flash_ctrl_enable), .running_flag(running_flag),
	.op_strobe(op_strobe), .op_code(op_code)
);

// File: sim/nfcc_flash_model.sv
`timescale 1ns/10ps

module nfcc_flash_model
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic op_strobe,
	input wire logic [2:0] op_code,
	output logic [7:0] op_count,
	output logic [2:0] last_op
);
	// ----------------------------------------------------------------
	// flash array side: counts each basic operation, keeps the last code
	// ----------------------------------------------------------------
	// basic operations taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_count <= 8'h00;
			last_op <= 3'h0;
		end
		else if (op_strobe)
		begin
			op_count <= op_count + 8'h01;
			last_op <= op_code;
		end
	end
endmodule

// File: sim/test_nand_flash_ctrl_config.sv
`timescale 1ns/10ps
`include "nfcc_defs.svh"

module test_nand_flash_ctrl_config;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, enable, running, op_strobe;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] op_code, last_op;
	wire [7:0] op_count;
	int n_mismatch = 0;
	int check_count = 0;

	nfcc_top i_nfcc_top
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.flash_ctrl_enable(enable), .running_flag(running), .op_strobe(op_strobe),
		.op_code(op_code)
	);

	nfcc_flash_model i_nfcc_flash_model
	(
		.aclk(aclk), .aresetn(aresetn), .op_strobe(op_strobe), .op_code(op_code),
		.op_count(op_count), .last_op(last_op)
	);

	// free running clock
	always #10 aclk = ~aclk;

	// ----------------------------------------------------------------
	// report, compare and bus tasks
	// ----------------------------------------------------------------
	task automatic final_report;
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// model count and last code, looked at once the strobe has settled
	task automatic chk_op(input logic [7:0] cnt, input logic [2:0] op);
		@(negedge aclk);
		chk({24'h0, op_count}, {24'h0, cnt});
		chk({29'h0, last_op}, {29'h0, op});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				done = 1'b1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
		if (!done)
		begin
			chk(32'h0, 32'h1);
			final_report;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 50)
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				done = 1'b1;
				rready <= 1'b0;
				chk(rdata, exp);
				chk({30'h0, rresp}, {30'h0, er});
			end
		end
		if (!done)
		begin
			chk(32'h0, 32'h1);
			final_report;
		end
	endtask

	// descriptor bytes lo..hi through the config port
	task automatic load(input logic [63:0] d, input int lo, input int hi);
		for (int i = lo; i <= hi; i++)
			wr(`NFCC_CFGPORT_OFS, {24'h0, d[8*i +: 8]}, 2'h0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`NFCC_GEOM_OFS, 32'h001E_0000, 2'h0);
		rd(`NFCC_PROT_OFS, 32'h0000_0000, 2'h0);
		wr(`NFCC_CFGPORT_OFS, 32'h0000_0055, 2'h0);
		rd(`NFCC_GEOM_OFS, 32'h001E_0000, 2'h0);
		wr(`NFCC_CTRL_OFS, 32'h0000_0001, 2'h0);
		rd(`NFCC_CTRL_OFS, 32'h0000_0001, 2'h0);
		wr(`NFCC_ACTION_OFS, 32'h0000_0001, 2'h0);
		chk_op(8'h00, 3'h0);
		rd(`NFCC_STATUS_OFS, 32'h0000_000C, 2'h0);
		wr(`NFCC_STATUS_OFS, 32'h0000_0008, 2'h0);
		load(64'h7856_3412_0160_0020, 0, 2);
		rd(`NFCC_STATUS_OFS, 32'h0000_0031, 2'h0);
		chk({31'h0, running}, 32'h1);
		load(64'h7856_3412_0160_0020, 3, 7);
		rd(`NFCC_GEOM_OFS, 32'h0160_0020, 2'h0);
		rd(`NFCC_PROT_OFS, 32'h7856_3412, 2'h0);
		rd(`NFCC_DERIV_OFS, 32'h0400_0040, 2'h0);
		rd(`NFCC_STATUS_OFS, 32'h0000_0002, 2'h0);
		for (int c = 1; c < 4; c++)
		begin
			wr(`NFCC_ACTION_OFS, 32'(c), 2'h0);
			chk_op(8'(c), 3'(c));
			rd(`NFCC_ACTION_OFS, 32'(c), 2'h0);
		end
		load(64'h0403_0201_0361_1010, 0, 7);
		rd(`NFCC_GEOM_OFS, 32'h0361_1010, 2'h0);
		rd(`NFCC_PROT_OFS, 32'h0403_0201, 2'h0);
		rd(`NFCC_DERIV_OFS, 32'h0200_0100, 2'h0);
		rd(`NFCC_STATUS_OFS, 32'h0000_0006, 2'h0);
		wr(`NFCC_ACTION_OFS, 32'h0000_0002, 2'h0);
		chk_op(8'h03, 3'h3);
		load(64'h0000_0000_0041_1010, 0, 7);
		rd(`NFCC_STATUS_OFS, 32'h0000_000A, 2'h0);
		rd(`NFCC_DERIV_OFS, 32'h0200_0020, 2'h0);
		wr(`NFCC_ACTION_OFS, 32'h0000_0003, 2'h0);
		chk_op(8'h04, 3'h3);
		wr(8'h1C, 32'h0000_0001, 2'h2);
		rd(8'h80, 32'h0000_0000, 2'h2);
		wr(`NFCC_CTRL_OFS, 32'h0000_0000, 2'h0);
		rd(`NFCC_CTRL_OFS, 32'h0000_0000, 2'h0);
		chk({31'h0, enable}, 32'h0);
		final_report;
	end
endmodule
